// ---- dscpm_params.svh ----
`ifndef DSCPM_PARAMS_SVH
`define DSCPM_PARAMS_SVH

// word index of each mapping register; byte address is four times the index
`define DSCPM_IDX_MAP_00_03 8'h90
`define DSCPM_IDX_MAP_04_07 8'h91
`define DSCPM_IDX_MAP_08_0B 8'h92
`define DSCPM_IDX_MAP_0C_0F 8'h93
`define DSCPM_IDX_MAP_10_13 8'h94
`define DSCPM_IDX_MAP_14_17 8'h95
`define DSCPM_IDX_MAP_18_1B 8'h96
`define DSCPM_IDX_MAP_1C_1F 8'h97
`define DSCPM_IDX_MAP_20_23 8'h98
`define DSCPM_IDX_BASE `DSCPM_IDX_MAP_00_03
`define DSCPM_IDX_W 8

// table shape
`define DSCPM_NUM_MAP_REGS 9
`define DSCPM_REG_W 8
`define DSCPM_ENTRY_W 2
`define DSCPM_MAP_RESET 8'h00
`define DSCPM_PRIO_DEFAULT 2'h0

// code point inside the service / traffic class byte
`define DSCPM_CODE_MSB 7
`define DSCPM_CODE_LSB 2
`define DSCPM_CODE_W 6
// code point split: register index and slot
`define DSCPM_CP_IDX_MSB 5
`define DSCPM_CP_IDX_LSB 2
`define DSCPM_CP_IDX_W 4
`define DSCPM_CP_SLOT_MSB 1
`define DSCPM_CP_SLOT_LSB 0

// bus fields
`define DSCPM_HADDR_IDX_MSB 9
`define DSCPM_HADDR_IDX_LSB 2
`define DSCPM_HTRANS_ACTIVE_BIT 1
`define DSCPM_HRESP_OKAY 1'b0
`define DSCPM_HRDATA_W 32

// reset synchroniser depth
`define DSCPM_RST_STAGES 2

`endif

// ---- dscpm_pkg.sv ----
`default_nettype none
package dscpm_pkg;
    typedef logic [1:0] dscpm_prio_type;
    typedef logic [5:0] dscpm_code_type;
    typedef logic [7:0] dscpm_map_type;
    // bus data phase tracking
    typedef enum logic [1:0] {
        PH_IDLE  = 2'h0,
        PH_RDATA = 2'h1,
        PH_WDATA = 2'h2
    } dscpm_phase_type;
endpackage
`default_nettype wire

// ---- dscpm_rst_sync.sv ----
`include "dscpm_params.svh"
`default_nettype none
module dscpm_rst_sync #(
    parameter int STAGES = `DSCPM_RST_STAGES
) (
    // clock and raw reset
    input wire logic sys_clk,
    input wire logic rstn,
    // released reset
    output logic rstnSync
);
    typedef struct packed {
        logic [STAGES-1:0] chain;
    } dscpm_rst_state_type;

    dscpm_rst_state_type s_q;
    dscpm_rst_state_type s_d;

    always_comb begin
        s_d = s_q;
        s_d.chain = {s_q.chain[STAGES-2:0], 1'b1};
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rstnSync = s_q.chain[STAGES-1];
endmodule
`default_nettype wire

// ---- dscpm_prio_lookup.sv ----
`include "dscpm_params.svh"
`default_nettype none
module dscpm_prio_lookup #(
    parameter int NUM_REGS = `DSCPM_NUM_MAP_REGS
) (
    // mapping table, register k in bits [8k+7:8k]
    input wire logic [NUM_REGS*`DSCPM_REG_W-1:0] mapTable,
    // code point of the frame
    input wire dscpm_pkg::dscpm_code_type codePoint,
    // looked-up entry
    output dscpm_pkg::dscpm_prio_type prio,
    output logic hit
);
    logic [`DSCPM_CP_IDX_W-1:0] regSel;
    logic [`DSCPM_CP_SLOT_MSB:0] slotSel;
    dscpm_pkg::dscpm_map_type regWord;

    always_comb begin
        // upper four bits pick the register, lower two the slot
        hit = ({1'b0, codePoint[`DSCPM_CP_IDX_MSB:`DSCPM_CP_IDX_LSB]} <
               (`DSCPM_CP_IDX_W+1)'(NUM_REGS));
        regSel = hit ? codePoint[`DSCPM_CP_IDX_MSB:`DSCPM_CP_IDX_LSB] : '0;
        slotSel = codePoint[`DSCPM_CP_SLOT_MSB:`DSCPM_CP_SLOT_LSB];
        regWord = mapTable[regSel*`DSCPM_REG_W +: `DSCPM_REG_W];
        // slot 0 sits in bits 1-0, slot 1 in bits 3-2, ascending
        prio = hit ? regWord[slotSel*`DSCPM_ENTRY_W +: `DSCPM_ENTRY_W] : `DSCPM_PRIO_DEFAULT;
    end
endmodule
`default_nettype wire

// ---- dscpm_map_top.sv ----
// Notes on behaviour
// - IP frames with code point up to 0x23 get the table entry indexed by service byte bits [7:2].
// - Code point 0x00 takes its priority from bits 1-0 of first register.
// - Code point 0x01 takes its priority from bits 3-2 of first register.
// - Register at index 0x95 holds code points 0x14-0x17 ascending, 0x17 in 7-6.
// - Code point 0x14 sits in bits 1-0 at 0x95, read/write, resets to 00.
// - Register at index 0x96 holds code points 0x18-0x1B, 0x1B in bits 7-6.
// - Eighth register holds code points 0x1C-0x1F, 0x1D in bits 3-2.
// - Ninth register places code point 0x23 in bits 7-6.
`include "dscpm_params.svh"
`default_nettype none
module dscpm_map_top #(
    parameter int NUM_REGS = `DSCPM_NUM_MAP_REGS
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // frame classification request
    input wire logic frmValid,
    input wire logic frmIsIp,
    input wire logic [7:0] frmTosByte,
    // classification answer
    output logic prioValid,
    output dscpm_pkg::dscpm_prio_type prioOut,
    output logic prioFromTable
);
    localparam int SLOT_W = (NUM_REGS > 1) ? $clog2(NUM_REGS) : 1;
    localparam int MAP_W = NUM_REGS * `DSCPM_REG_W;

    typedef struct packed {
        logic [MAP_W-1:0] map;
        dscpm_pkg::dscpm_phase_type phase;
        logic [`DSCPM_IDX_W-1:0] idx;
        logic [`DSCPM_HRDATA_W-1:0] rdata;
        logic readyOut;
        logic resp;
        logic prioValid;
        dscpm_pkg::dscpm_prio_type prio;
        logic fromTable;
    } dscpm_top_state_type;

    localparam dscpm_top_state_type STATE_RESET = '{
        map: {NUM_REGS{`DSCPM_MAP_RESET}},
        phase: dscpm_pkg::PH_IDLE,
        idx: '0,
        rdata: '0,
        readyOut: 1'b1,
        resp: `DSCPM_HRESP_OKAY,
        prioValid: 1'b0,
        prio: `DSCPM_PRIO_DEFAULT,
        fromTable: 1'b0
    };

    // word index decoding, shared by the write and read paths
    function automatic logic isMapIdx(input logic [`DSCPM_IDX_W-1:0] idx);
        isMapIdx = (idx >= `DSCPM_IDX_BASE) &&
                   ({1'b0, idx} < ((`DSCPM_IDX_W+1)'(`DSCPM_IDX_BASE) +
                                   (`DSCPM_IDX_W+1)'(NUM_REGS)));
    endfunction

    function automatic logic [SLOT_W-1:0] slotOf(input logic [`DSCPM_IDX_W-1:0] idx);
        logic [`DSCPM_IDX_W-1:0] diff;
        diff = idx - `DSCPM_IDX_BASE;
        slotOf = diff[SLOT_W-1:0];
    endfunction

    logic rstnSync;
    dscpm_pkg::dscpm_prio_type lookPrio;
    logic lookHit;
    dscpm_top_state_type s_q;
    dscpm_top_state_type s_d;
    logic addrTake;
    logic [`DSCPM_IDX_W-1:0] newIdx;
    dscpm_pkg::dscpm_code_type codePoint;

    dscpm_rst_sync #(
        .STAGES(`DSCPM_RST_STAGES)
    ) u_rst_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .rstnSync(rstnSync)
    );

    // service byte bits [7:2] give the code point
    assign codePoint = frmTosByte[`DSCPM_CODE_MSB:`DSCPM_CODE_LSB];

    // lookup reads the registered table only, so a write lands for later frames
    dscpm_prio_lookup #(
        .NUM_REGS(NUM_REGS)
    ) u_lookup (
        .mapTable(s_q.map),
        .codePoint(codePoint),
        .prio(lookPrio),
        .hit(lookHit)
    );

    always_comb begin
        s_d = s_q;
        s_d.readyOut = 1'b1;
        s_d.resp = `DSCPM_HRESP_OKAY;
        addrTake = hsel && htrans[`DSCPM_HTRANS_ACTIVE_BIT] && hready;
        newIdx = haddr[`DSCPM_HADDR_IDX_MSB:`DSCPM_HADDR_IDX_LSB];

        // data phase of a write: only the addressed byte-wide register changes
        // four 2-bit entries per register, lowest code point in bits 1-0
        if (s_q.phase == dscpm_pkg::PH_WDATA && isMapIdx(s_q.idx)) begin
            s_d.map[slotOf(s_q.idx)*`DSCPM_REG_W +: `DSCPM_REG_W] =
                hwdata[`DSCPM_REG_W-1:0];
        end

        // address phase; reads see a write completing in this same cycle
        if (addrTake) begin
            s_d.idx = newIdx;
            if (hwrite) begin
                s_d.phase = dscpm_pkg::PH_WDATA;
            end else begin
                s_d.phase = dscpm_pkg::PH_RDATA;
                s_d.rdata = '0;
                if (isMapIdx(newIdx)) begin
                    s_d.rdata[`DSCPM_REG_W-1:0] =
                        s_d.map[slotOf(newIdx)*`DSCPM_REG_W +: `DSCPM_REG_W];
                end
            end
        end else begin
            s_d.phase = dscpm_pkg::PH_IDLE;
        end

        // classification, one cycle of latency
        s_d.prioValid = frmValid;
        if (frmValid) begin
            s_d.fromTable = frmIsIp && lookHit;
            s_d.prio = (frmIsIp && lookHit) ? lookPrio : `DSCPM_PRIO_DEFAULT;
        end
    end

    always_ff @(posedge sys_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            s_q <= STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata = s_q.rdata;
    assign hreadyout = s_q.readyOut;
    assign hresp = s_q.resp;
    assign prioValid = s_q.prioValid;
    assign prioOut = s_q.prio;
    assign prioFromTable = s_q.fromTable;
endmodule
`default_nettype wire

// ---- dscpm_map_chk.sv ----
`default_nettype none
module dscpm_map_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // classification
    input wire logic frmValid,
    input wire logic frmIsIp,
    input wire logic [7:0] frmTosByte,
    input wire logic prioValid,
    input wire dscpm_pkg::dscpm_prio_type prioOut,
    input wire logic prioFromTable,
    // bus answer
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    property p_answer; frmValid |=> prioValid; endproperty
    a_answer: assert property (p_answer) else $error("no answer after frame");
    property p_pulse; !frmValid |=> !prioValid; endproperty
    a_pulse: assert property (p_pulse) else $error("answer without frame");
    property p_nonip; frmValid && !frmIsIp |=> prioOut == 2'h0 && !prioFromTable; endproperty
    a_nonip: assert property (p_nonip) else $error("non-ip frame used table");
    property p_intab;
        frmValid && frmIsIp && frmTosByte[7:2] <= 6'h23 |=> prioFromTable;
    endproperty
    a_intab: assert property (p_intab) else $error("mapped code point missed table");
    property p_over; frmValid && frmTosByte[7:2] > 6'h23 |=> !prioFromTable; endproperty
    a_over: assert property (p_over) else $error("unmapped code point hit table");
    property p_hold;
        !frmValid |=> $stable(prioOut) && $stable(prioFromTable);
    endproperty
    a_hold: assert property (p_hold) else $error("priority changed without frame");
    property p_okay; hreadyout && hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("bus not ready or not okay");
    property p_upper; hrdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("read data upper bits set");
endmodule
bind dscpm_map_top dscpm_map_chk dscpm_map_chk_i (.sys_clk, .rstn, .frmValid, .frmIsIp,
    .frmTosByte, .prioValid, .prioOut, .prioFromTable, .hrdata, .hreadyout, .hresp);
`default_nettype wire

// ---- ip_dscp_priority_map_tb_top.sv ----
`default_nettype none
module ip_dscp_priority_map_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rstn = 0, hsel = 0, hwrite = 0, frmValid = 0, frmIsIp = 0, hready;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [7:0] frmTosByte = 0;
    logic hreadyout, hresp, prioValid, prioFromTable;
    dscpm_pkg::dscpm_prio_type prioOut;
    logic [7:0] mdl [10] = '{default: 8'h0};
    int seed = 15, nMismatch = 0, comparisons = 0, idx;
    // write value kept apart from rd, which the bus task overwrites with read data
    logic [7:0] wv;
    assign hready = hreadyout;
    dscpm_map_top dscpm_map_top_i (.sys_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hrdata, .hreadyout, .hresp, .frmValid, .frmIsIp, .frmTosByte,
        .prioValid, .prioOut, .prioFromTable);
    initial forever #4 sys_clk = ~sys_clk;
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            nMismatch++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("mismatches %0d comparisons %0d", nMismatch, comparisons);
        if (nMismatch == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task bus(input logic [7:0] ix, input logic wr, input logic [7:0] wd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= {22'h0, ix, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge sys_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge sys_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // expected {from table, priority}; unmapped words in mdl stay zero
    function automatic logic [2:0] expPrio(input logic ip, input logic [7:0] tos);
        if (!ip || tos[7:2] > 6'h23) return 3'h0;
        return {1'b1, mdl[tos[7:4]][2 * tos[3:2] +: 2]};
    endfunction
    // sweeps every code point, then random frames with gaps, answers checked back to back
    task frames(input int n);
        logic [31:0] r;
        logic [2:0] prev;
        logic pv, v, ip;
        logic [7:0] tos;
        pv = 0;
        for (int i = 0; i <= n; i++) begin
            r = $random(seed);
            v = i < n && (i < 64 || r[9]);
            ip = i < 64 || r[8];
            tos = i < 64 ? {i[5:0], r[1:0]} : r[7:0];
            @(posedge sys_clk);
            frmValid <= v;
            frmIsIp <= ip;
            frmTosByte <= tos;
            #1;
            if (pv) check({prioValid, prioFromTable, prioOut}, {1'b1, prev});
            else check(prioValid, 1'b0);
            pv = v;
            prev = expPrio(ip, tos);
        end
    endtask
    task readall;
        for (int k = 0; k < 10; k++) begin
            bus(8'h90 + k[7:0], 1'b0, 8'h0);
            check(rd, {24'h0, mdl[k]});
        end
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        readall;
        frames(80);
        // distinct slot values so slot order shows; index 0x99 is unmapped
        for (int k = 0; k < 10; k++) begin
            bus(8'h90 + k[7:0], 1'b1, 8'hE4);
            if (k < 9) mdl[k] = 8'hE4;
        end
        readall;
        frames(70);
        repeat (12) begin
            idx = $unsigned($random(seed)) % 10;
            rd = $random(seed);
            wv = rd[7:0];
            bus(8'h90 + idx[7:0], 1'b1, wv);
            if (idx < 9) mdl[idx] = wv;
            frames(80);
            readall;
        end
        test_done;
    end
    initial begin
        #200us;
        nMismatch++;
        test_done;
    end
endmodule
`default_nettype wire
